// File: hw/sxp_pkg.sv
// package: offsets, fields, resets and types of the servo extension parameters
package sxp_pkg;

   // ==========================
   // register offsets
   localparam logic [15:0] SXP_OFS_CLR_MODE = 16'h0264;
   localparam logic [15:0] SXP_OFS_IGAIN = 16'h026A;
   localparam logic [15:0] SXP_OFS_NUM2 = 16'h0278;
   localparam logic [15:0] SXP_OFS_NUM3 = 16'h027A;
   localparam logic [15:0] SXP_OFS_NUM4 = 16'h027C;
   localparam logic [15:0] SXP_OFS_SF1 = 16'h0282;
   localparam logic [15:0] SXP_OFS_SF2 = 16'h0284;
   localparam logic [15:0] SXP_OFS_JLVL = 16'h0286;
   localparam logic [15:0] SXP_OFS_AUTO = 16'h0288;

   // ==========================
   // reset values
   localparam logic [15:0] SXP_RST_CLR_MODE = 16'h0000;
   localparam logic [15:0] SXP_RST_IGAIN = 16'h0000;
   localparam logic [31:0] SXP_RST_NUM2 = 32'h0000_0001;
   localparam logic [31:0] SXP_RST_NUM3 = 32'h0000_0080;
   localparam logic [31:0] SXP_RST_NUM4 = 32'h0000_0001;
   localparam logic [15:0] SXP_RST_SF = 16'h0000;
   localparam logic [15:0] SXP_RST_JLVL = 16'h000F;
   localparam logic [15:0] SXP_RST_AUTO = 16'h0000;

   // ==========================
   // limits and field positions
   localparam logic [15:0] SXP_IGAIN_MAX = 16'h03FF;
   localparam logic [31:0] SXP_NUM_MAX = 32'h1FFF_FFFF;
   localparam int SXP_SF1_SPD_EDGE = 0;
   localparam int SXP_SF1_TRQ_EDGE = 1;
   localparam int SXP_SF1_ABN_DIS = 6;
   localparam int SXP_SF1_WIRE_ERR = 8;
   localparam int SXP_SF1_WIRE_CUT = 9;
   localparam int SXP_SF1_CLAMP = 10;
   localparam int SXP_SF1_INHIBIT = 11;
   localparam int SXP_SF1_PHASE_DIS = 12;
   localparam int SXP_SF1_ENC_DIS = 13;
   localparam int SXP_SF2_UV_AUTO = 2;
   localparam int SXP_AUTO_X = 0;
   localparam int SXP_AUTO_Y = 4;
   localparam logic [15:0] SXP_RAMP_STEP = 16'h0010;

   // ==========================
   // types
   typedef enum logic [3:0]
   {
      SXP_MODE_PPOS = 4'h1,
      SXP_MODE_IPOS = 4'h2,
      SXP_MODE_SPD = 4'h4,
      SXP_MODE_TRQ = 4'h8
   } sxp_mode_e;

   typedef enum logic [1:0]
   {
      SXP_EN_OFF = 2'h1,
      SXP_EN_ON = 2'h2
   } sxp_en_e;

   typedef struct packed
   {
      logic clear;
      logic num_assigned;
      logic [1:0] num_sel;
      logic [1:0] spd_sel;
      logic [1:0] trq_sel;
      logic zero_speed_hold;
      logic fwd_limit;
      logic rev_limit;
      logic servo_on;
      logic alarm_reset;
   } sxp_di_s;

   typedef struct packed
   {
      logic abn_pulse;
      logic wire_err;
      logic wire_cut;
      logic phase_loss;
      logic enc_out;
   } sxp_det_s;

endpackage

// File: hw/sxp_servo_ext.sv
// servo extension parameter block: registers and the logic they steer
//
// Implementation choice: the plain strobed port.
`timescale 1ns/10ps

// Notes on behaviour
// - clear input zeroes pulse count in position modes
// - clear mode 0 rising edge, 1 level
// - integral gain 0 to 1023, default 0
// - gear numerator chosen from alternates by selects
// - bit 0 speed selects level or edge
// - bit 1 torque selects level or edge
// - bit 6 set disables abnormal pulse detection
// - bits 8, 9 enable wiring checks
// - clamp needs speed mode, input, low command
// - clamp bit set: internal zero, analog ramps
// - inhibit on blocks pulses toward active limit
// - inhibit off accepts pulses whatever the limits
// - bit 12 set disables phase loss detection
// - bit 13 set disables encoder output detection
// - undervoltage alarm auto clears when bit set
// - re-estimate inertia outside band around ratio
// - auto enable: X picks trigger or level
// - auto limit: Y lets the limit alarm clear alone
module sxp_servo_ext
   import sxp_pkg::*;
#(
   parameter int NUM_W = 32,
   parameter int CNT_W = 32
)
(
   // clock, reset, enable
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic ce_in,
   // register port
   input wire logic [15:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rdata_out,
   // mode and discrete inputs
   input wire sxp_mode_e mode_in,
   input wire sxp_di_s di_in,
   input wire logic main_power_in,
   // pulse train
   input wire logic pulse_in,
   input wire logic pulse_dir_in,
   output logic [CNT_W-1:0] pulse_count_out,
   output logic pulse_accept_out,
   // gear numerator and integral gain
   input wire logic [NUM_W-1:0] default_numerator_in,
   output logic [NUM_W-1:0] gear_numerator_out,
   output logic [15:0] position_integral_gain_out,
   // speed and torque selects
   output logic [1:0] speed_select_out,
   output logic [1:0] torque_select_out,
   // zero speed clamp
   input wire logic [15:0] speed_cmd_in,
   input wire logic analog_source_in,
   input wire logic [15:0] clamp_threshold_in,
   output logic [15:0] speed_cmd_out,
   output logic clamp_active_out,
   output logic clamp_lock_out,
   // detection enables, alarms and motor enable
   output sxp_det_s det_en_out,
   input wire logic undervoltage_in,
   output logic undervoltage_alarm_out,
   output logic limit_alarm_out,
   output logic motor_enable_out,
   // inertia estimation
   input wire logic semi_auto_in,
   input wire logic [15:0] inertia_ratio_in,
   input wire logic [15:0] inertia_measured_in,
   output logic reestimate_out
);

   // ==========================
   // helpers
   function automatic logic [31:0] sxp_num_fit(input logic [31:0] v);
      logic [31:0] r;
      r = v;
      if (v > SXP_NUM_MAX)
         r = SXP_NUM_MAX;
      if (v == 32'h0000_0000)
         r = 32'h0000_0001;
      return r;
   endfunction

   function automatic logic sxp_rise(input logic now, input logic was);
      return now & ~was;
   endfunction

   function automatic logic [31:0] rd_inhold(input logic rd, input logic [31:0] v);
      return rd ? v : 32'h0000_0000;
   endfunction

   // ==========================
   // registers
   logic [15:0] clr_mode_r;
   logic [15:0] igain_r;
   logic [31:0] num2_r;
   logic [31:0] num3_r;
   logic [31:0] num4_r;
   logic [15:0] sf1_r;
   logic [15:0] sf2_r;
   logic [15:0] jlvl_r;
   logic [15:0] auto_r;

   wire logic hit_clr = addr_in == SXP_OFS_CLR_MODE;
   wire logic hit_igain = addr_in == SXP_OFS_IGAIN;
   wire logic hit_num2 = addr_in == SXP_OFS_NUM2;
   wire logic hit_num3 = addr_in == SXP_OFS_NUM3;
   wire logic hit_num4 = addr_in == SXP_OFS_NUM4;
   wire logic hit_sf1 = addr_in == SXP_OFS_SF1;
   wire logic hit_sf2 = addr_in == SXP_OFS_SF2;
   wire logic hit_jlvl = addr_in == SXP_OFS_JLVL;
   wire logic hit_auto = addr_in == SXP_OFS_AUTO;

   wire logic [15:0] wlow = wdata_in[15:0];
   wire logic [15:0] igain_fit = (wlow > SXP_IGAIN_MAX) ? SXP_IGAIN_MAX : wlow;
   wire logic [31:0] num_fit = sxp_num_fit(wdata_in);
   // reserved function bits are kept as written and read back
   wire logic [31:0] rd_mux =
      hit_clr ? {16'h0000, clr_mode_r} :
      hit_igain ? {16'h0000, igain_r} :
      hit_num2 ? num2_r :
      hit_num3 ? num3_r :
      hit_num4 ? num4_r :
      hit_sf1 ? {16'h0000, sf1_r} :
      hit_sf2 ? {16'h0000, sf2_r} :
      hit_jlvl ? {16'h0000, jlvl_r} :
      hit_auto ? {16'h0000, auto_r} : 32'h0000_0000;

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         clr_mode_r <= SXP_RST_CLR_MODE;
         igain_r <= SXP_RST_IGAIN;
         num2_r <= SXP_RST_NUM2;
         num3_r <= SXP_RST_NUM3;
         num4_r <= SXP_RST_NUM4;
         sf1_r <= SXP_RST_SF;
         sf2_r <= SXP_RST_SF;
         jlvl_r <= SXP_RST_JLVL;
         auto_r <= SXP_RST_AUTO;
         rdata_out <= 32'h0000_0000;
      end
      else if (ce_in)
      begin
         if (wr_in && hit_clr)
            clr_mode_r <= wlow;
         if (wr_in && hit_igain)
            igain_r <= igain_fit;
         if (wr_in && hit_num2)
            num2_r <= num_fit;
         if (wr_in && hit_num3)
            num3_r <= num_fit;
         if (wr_in && hit_num4)
            num4_r <= num_fit;
         if (wr_in && hit_sf1)
            sf1_r <= wlow;
         if (wr_in && hit_sf2)
            sf2_r <= wlow;
         if (wr_in && hit_jlvl)
            jlvl_r <= wlow;
         if (wr_in && hit_auto)
            auto_r <= wlow;
         rdata_out <= rd_inhold(rd_in, rd_mux);
      end
   end


   // ==========================
   // input history for edge detection
   logic clear_d_r;
   logic [1:0] spd_d_r;
   logic [1:0] trq_d_r;
   logic srv_on_d_r;

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         clear_d_r <= 1'b0;
         spd_d_r <= 2'b00;
         trq_d_r <= 2'b00;
         srv_on_d_r <= 1'b0;
      end
      else if (ce_in)
      begin
         clear_d_r <= di_in.clear;
         spd_d_r <= di_in.spd_sel;
         trq_d_r <= di_in.trq_sel;
         srv_on_d_r <= di_in.servo_on;
      end
   end

   // ==========================
   // pulse count, clear and limit inhibit
   wire logic pos_mode = (mode_in == SXP_MODE_PPOS) || (mode_in == SXP_MODE_IPOS);
   wire logic clr_level = clr_mode_r[0];
   wire logic clr_trig = clr_level ? di_in.clear : sxp_rise(di_in.clear, clear_d_r);
   wire logic clr_hit = pos_mode && clr_trig;
   wire logic inhibit = sf1_r[SXP_SF1_INHIBIT] && (mode_in == SXP_MODE_PPOS);
   wire logic to_limit = pulse_dir_in ? di_in.fwd_limit : di_in.rev_limit;
   wire logic blocked = inhibit && to_limit;
   wire logic take = pulse_in && (mode_in == SXP_MODE_PPOS) && !blocked;
   wire logic [CNT_W-1:0] one = {{(CNT_W-1){1'b0}}, 1'b1};

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         pulse_count_out <= '0;
         pulse_accept_out <= 1'b0;
      end
      else if (ce_in)
      begin
         pulse_accept_out <= take;
         if (clr_hit)
            pulse_count_out <= '0;
         else if (take)
            pulse_count_out <= pulse_dir_in ? pulse_count_out + one : pulse_count_out - one;
      end
   end

   // ==========================
   // gear numerator and integral gain
   wire logic [NUM_W-1:0] num_sel_val =
      !di_in.num_assigned ? default_numerator_in :
      (di_in.num_sel == 2'b01) ? num2_r[NUM_W-1:0] :
      (di_in.num_sel == 2'b10) ? num3_r[NUM_W-1:0] :
      (di_in.num_sel == 2'b11) ? num4_r[NUM_W-1:0] :
      default_numerator_in;

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         gear_numerator_out <= '0;
         position_integral_gain_out <= SXP_RST_IGAIN;
      end
      else if (ce_in)
      begin
         gear_numerator_out <= num_sel_val;
         position_integral_gain_out <= igain_r;
      end
   end

   // ==========================
   // speed and torque select triggering
   wire logic spd_edge = sf1_r[SXP_SF1_SPD_EDGE];
   wire logic trq_edge = sf1_r[SXP_SF1_TRQ_EDGE];
   wire logic spd_rise = |(di_in.spd_sel & ~spd_d_r);
   wire logic trq_rise = |(di_in.trq_sel & ~trq_d_r);

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         speed_select_out <= 2'b00;
         torque_select_out <= 2'b00;
      end
      else if (ce_in)
      begin
         if (!spd_edge || spd_rise)
            speed_select_out <= di_in.spd_sel;
         if (!trq_edge || trq_rise)
            torque_select_out <= di_in.trq_sel;
      end
   end

   // ==========================
   // zero speed clamp
   wire logic [15:0] cmd_mag = speed_cmd_in[15] ? 16'(-speed_cmd_in) : speed_cmd_in;
   wire logic clamp_cond = (mode_in == SXP_MODE_SPD) && di_in.zero_speed_hold
      && (cmd_mag < clamp_threshold_in);
   wire logic clamp_sel = sf1_r[SXP_SF1_CLAMP];
   wire logic [15:0] out_mag = speed_cmd_out[15] ? 16'(-speed_cmd_out) : speed_cmd_out;
   wire logic ramp_done = out_mag <= SXP_RAMP_STEP;
   wire logic [15:0] ramp_val = speed_cmd_out[15] ? 16'(speed_cmd_out + SXP_RAMP_STEP)
      : 16'(speed_cmd_out - SXP_RAMP_STEP);
   wire logic [15:0] clamp_cmd =
      !(clamp_cond && clamp_sel) ? speed_cmd_in :
      !analog_source_in ? 16'h0000 :
      ramp_done ? 16'h0000 : ramp_val;

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         speed_cmd_out <= 16'h0000;
         clamp_active_out <= 1'b0;
         clamp_lock_out <= 1'b0;
      end
      else if (ce_in)
      begin
         speed_cmd_out <= clamp_cmd;
         clamp_active_out <= clamp_cond;
         clamp_lock_out <= clamp_cond && !clamp_sel;
      end
   end

   // ==========================
   // detection enables
   wire sxp_det_s det_nxt = '{
      abn_pulse: !sf1_r[SXP_SF1_ABN_DIS],
      wire_err: sf1_r[SXP_SF1_WIRE_ERR],
      wire_cut: sf1_r[SXP_SF1_WIRE_CUT],
      phase_loss: !sf1_r[SXP_SF1_PHASE_DIS],
      enc_out: !sf1_r[SXP_SF1_ENC_DIS]
   };

   // ==========================
   // alarms and auto enable
   wire logic uv_auto = sf2_r[SXP_SF2_UV_AUTO];
   wire logic auto_x = auto_r[SXP_AUTO_X];
   wire logic auto_y = auto_r[SXP_AUTO_Y];
   wire logic lim_now = di_in.fwd_limit || di_in.rev_limit;
   wire logic uv_clr = di_in.alarm_reset || uv_auto;
   wire logic lim_clr = di_in.alarm_reset || auto_y;
   wire logic en_ok = main_power_in && di_in.servo_on;
   wire logic en_go = auto_x ? en_ok : en_ok && sxp_rise(di_in.servo_on, srv_on_d_r);
   sxp_en_e en_r;
   sxp_en_e en_nxt;

   always_comb
   begin
      en_nxt = en_r;
      unique case (en_r)
         SXP_EN_OFF:
         begin
            if (en_go)
               en_nxt = SXP_EN_ON;
         end
         SXP_EN_ON:
         begin
            if (!en_ok)
               en_nxt = SXP_EN_OFF;
         end
         default:
         begin
            en_nxt = SXP_EN_OFF;
         end
      endcase
   end

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         det_en_out <= '0;
         undervoltage_alarm_out <= 1'b0;
         limit_alarm_out <= 1'b0;
         en_r <= SXP_EN_OFF;
         motor_enable_out <= 1'b0;
      end
      else if (ce_in)
      begin
         det_en_out <= det_nxt;
         // a live event wins over a clear
         if (undervoltage_in)
            undervoltage_alarm_out <= 1'b1;
         else if (uv_clr)
            undervoltage_alarm_out <= 1'b0;
         if (lim_now)
            limit_alarm_out <= 1'b1;
         else if (lim_clr)
            limit_alarm_out <= 1'b0;
         en_r <= en_nxt;
         motor_enable_out <= en_nxt == SXP_EN_ON;
      end
   end

   // ==========================
   // inertia re-estimation band, in doubled tenths
   wire logic [17:0] meas2 = {1'b0, inertia_measured_in, 1'b0};
   wire logic [17:0] ratio2 = {1'b0, inertia_ratio_in, 1'b0};
   wire logic [17:0] band = {2'b00, jlvl_r};
   wire logic [17:0] hi = 18'(ratio2 + band);
   wire logic [17:0] lo = (ratio2 > band) ? 18'(ratio2 - band) : 18'h00000;
   wire logic outside = (meas2 > hi) || (meas2 < lo);

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
         reestimate_out <= 1'b0;
      else if (ce_in)
         reestimate_out <= semi_auto_in && outside;
   end

endmodule

// File: sim/sxp_pulse_src.sv
// partner: pulse-train command source with its direction line
`timescale 1ns/10ps
module sxp_pulse_src
(
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // train request
   input wire logic go_in,
   input wire logic dir_in,
   input wire logic [7:0] len_in,
   input wire logic slow_in,
   // pulse lines
   output logic pulse_out,
   output logic dir_out,
   output logic busy_out
);
   logic [7:0] left_r;
   logic dir_r;
   logic gap_r;

   // ==========================
   // train state, slow trains leave a gap cycle
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         left_r <= 8'h00;
         dir_r <= 1'b0;
         gap_r <= 1'b0;
      end
      else if (go_in && !busy_out)
      begin
         left_r <= len_in;
         dir_r <= dir_in;
         gap_r <= 1'b0;
      end
      else if (busy_out)
      begin
         left_r <= left_r - {7'h00, pulse_out};
         gap_r <= slow_in && !gap_r;
      end
   end

   // ==========================
   // idle direction line flips so no stale value is seen
   assign busy_out = (left_r != 8'h00);
   assign pulse_out = busy_out && !gap_r;
   assign dir_out = busy_out ? dir_r : !dir_r;
endmodule

// File: sim/sxp_servo_ext_props.sv
// checker: timing relations at the servo extension ports
`timescale 1ns/10ps
module sxp_servo_ext_props
   import sxp_pkg::*;
#(
   parameter int NUM_W = 32,
   parameter int CNT_W = 32
)
(
   // clock, reset, enable
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic ce_in,
   // watched inputs
   input wire sxp_mode_e mode_in,
   input wire sxp_di_s di_in,
   input wire logic pulse_in,
   input wire logic pulse_dir_in,
   input wire logic [NUM_W-1:0] default_numerator_in,
   input wire logic undervoltage_in,
   input wire logic main_power_in,
   input wire logic semi_auto_in,
   // watched outputs
   input wire logic [CNT_W-1:0] pulse_count_out,
   input wire logic pulse_accept_out,
   input wire logic [NUM_W-1:0] gear_numerator_out,
   input wire logic clamp_active_out,
   input wire logic undervoltage_alarm_out,
   input wire logic limit_alarm_out,
   input wire logic motor_enable_out,
   input wire logic reestimate_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (reset_in);

   // ==========================
   // sequences
   sequence s_clr_rise;
      (ce_in && !di_in.clear) ##1
      (ce_in && di_in.clear && (mode_in == SXP_MODE_PPOS || mode_in == SXP_MODE_IPOS));
   endsequence
   sequence s_free_fwd;
      ce_in && pulse_in && pulse_dir_in && mode_in == SXP_MODE_PPOS && !di_in.clear
      && !di_in.fwd_limit && !di_in.rev_limit;
   endsequence

   // ==========================
   // properties
   property p_clr;
      s_clr_rise |=> pulse_count_out == '0;
   endproperty
   a_clr: assert property (p_clr) else $error("count not cleared");
   property p_free;
      s_free_fwd |=> pulse_accept_out && pulse_count_out == $past(pulse_count_out) + 1'b1;
   endproperty
   a_free: assert property (p_free) else $error("free pulse not counted");
   property p_num;
      ce_in && (!di_in.num_assigned || di_in.num_sel == 2'h0)
      |=> gear_numerator_out == $past(default_numerator_in);
   endproperty
   a_num: assert property (p_num) else $error("default numerator not used");
   property p_clamp;
      ce_in && (mode_in != SXP_MODE_SPD || !di_in.zero_speed_hold) |=> !clamp_active_out;
   endproperty
   a_clamp: assert property (p_clamp) else $error("clamp without condition");
   property p_uv;
      ce_in && undervoltage_in |=> undervoltage_alarm_out;
   endproperty
   a_uv: assert property (p_uv) else $error("undervoltage alarm missing");
   property p_limit;
      ce_in && (di_in.fwd_limit || di_in.rev_limit) |=> limit_alarm_out;
   endproperty
   a_limit: assert property (p_limit) else $error("limit alarm missing");
   property p_power;
      ce_in && !main_power_in |=> !motor_enable_out;
   endproperty
   a_power: assert property (p_power) else $error("enabled without power");
   property p_reest;
      ce_in && !semi_auto_in |=> !reestimate_out;
   endproperty
   a_reest: assert property (p_reest) else $error("re-estimate outside tuning");
endmodule

bind sxp_servo_ext sxp_servo_ext_props #(.NUM_W(NUM_W), .CNT_W(CNT_W)) i_sxp_servo_ext_props
(
   .clk_in, .reset_in, .ce_in, .mode_in, .di_in, .pulse_in, .pulse_dir_in,
   .default_numerator_in, .undervoltage_in, .main_power_in, .semi_auto_in,
   .pulse_count_out, .pulse_accept_out, .gear_numerator_out, .clamp_active_out,
   .undervoltage_alarm_out, .limit_alarm_out, .motor_enable_out, .reestimate_out
);

// File: sim/sxp_servo_ext_tb.sv
// testbench: registers and port behaviour of the servo extension block
`timescale 1ns/10ps
module sxp_servo_ext_tb
   import sxp_pkg::*;
   ;
   logic clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic ce_in = 1'b1;
   logic [15:0] addr_in = 16'h0000;
   logic [31:0] wdata_in = 32'h0000_0000;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   sxp_mode_e mode_in = SXP_MODE_PPOS;
   sxp_di_s di_in = '0;
   logic main_power_in = 1'b0;
   logic undervoltage_in = 1'b0;
   logic analog_source_in = 1'b0;
   logic semi_auto_in = 1'b0;
   logic [31:0] default_numerator_in = 32'h0000_0055;
   logic [15:0] speed_cmd_in = 16'h0005;
   logic [15:0] clamp_threshold_in = 16'h0010;
   logic [15:0] inertia_ratio_in = 16'h0014;
   logic [15:0] inertia_measured_in = 16'h0014;
   logic go = 1'b0;
   logic dir = 1'b1;
   logic slow = 1'b0;
   logic [7:0] len = 8'h00;
   logic pulse_in, pulse_dir_in, busy, pulse_accept_out, clamp_active_out, clamp_lock_out;
   logic undervoltage_alarm_out, limit_alarm_out, motor_enable_out, reestimate_out;
   logic [31:0] rdata_out, pulse_count_out, gear_numerator_out;
   logic [15:0] position_integral_gain_out, speed_cmd_out;
   logic [1:0] speed_select_out, torque_select_out;
   sxp_det_s det_en_out;
   int n_errors = 0;
   int n_tests = 0;
   localparam logic [15:0] OA [10] = '{SXP_OFS_CLR_MODE, SXP_OFS_IGAIN, SXP_OFS_NUM2,
      SXP_OFS_NUM3, SXP_OFS_NUM4, SXP_OFS_SF1, SXP_OFS_SF2, SXP_OFS_JLVL, SXP_OFS_AUTO, 16'h0266};
   localparam logic [31:0] OV [10] = '{32'h0, 32'h0, 32'h1, 32'h80, 32'h1, 32'h0, 32'h0,
      32'hF, 32'h0, 32'h0};
   localparam logic [31:0] NX [5] = '{32'h1FFF_FFFF, 32'h1234, 32'h1, 32'h55, 32'h55};
   localparam logic [15:0] SV [3] = '{16'h0000, 16'h3340, 16'h0200};
   localparam logic [4:0] DX [3] = '{5'h13, 5'h0C, 5'h17};

   // ==========================
   // clock, design and partner
   always #25 clk_in = ~clk_in;
   sxp_servo_ext i_sxp_servo_ext (.clk_in, .reset_in, .ce_in, .addr_in, .wdata_in, .wr_in,
      .rd_in, .rdata_out, .mode_in, .di_in, .main_power_in, .pulse_in, .pulse_dir_in,
      .pulse_count_out, .pulse_accept_out, .default_numerator_in, .gear_numerator_out,
      .position_integral_gain_out, .speed_select_out, .torque_select_out, .speed_cmd_in,
      .analog_source_in, .clamp_threshold_in, .speed_cmd_out, .clamp_active_out,
      .clamp_lock_out, .det_en_out, .undervoltage_in, .undervoltage_alarm_out,
      .limit_alarm_out, .motor_enable_out, .semi_auto_in, .inertia_ratio_in,
      .inertia_measured_in, .reestimate_out);
   sxp_pulse_src i_sxp_pulse_src (.clk_in, .reset_in, .go_in(go), .dir_in(dir), .len_in(len),
      .slow_in(slow), .pulse_out(pulse_in), .dir_out(pulse_dir_in), .busy_out(busy));

   // ==========================
   // tasks
   task t();
      @(posedge clk_in);
   endtask
   task s1();
      t();
      #1;
   endtask
   task ck(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e)
      begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task wr(input logic [15:0] a, input logic [31:0] d);
      t();
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      t();
      wr_in <= 1'b0;
   endtask
   task rd(input logic [15:0] a, input logic [31:0] e);
      t();
      addr_in <= a;
      rd_in <= 1'b1;
      t();
      rd_in <= 1'b0;
      #1;
      ck(rdata_out, e);
   endtask
   task pl(input logic d, input logic [7:0] n, input logic s, input logic [31:0] e);
      t();
      go <= 1'b1;
      dir <= d;
      len <= n;
      slow <= s;
      t();
      go <= 1'b0;
      s1();
      while (busy)
         s1();
      ck(pulse_count_out, e);
   endtask
   task conclude();
      if (n_errors == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // ==========================
   // watchdog
   initial
   begin
      repeat (5000) t();
      n_errors++;
      conclude();
   end

   // ==========================
   // test sequence
   initial
   begin
      repeat (16) t();
      reset_in <= 1'b0;
      for (int i = 0; i < 10; i++)
         rd(OA[i], OV[i]);
      wr(SXP_OFS_IGAIN, 32'h0000_0500);
      rd(SXP_OFS_IGAIN, 32'h3FF);
      ck(position_integral_gain_out, 32'h3FF);
      t();
      ce_in <= 1'b0;
      wr(SXP_OFS_IGAIN, 32'h0000_0007);
      ce_in <= 1'b1;
      rd(SXP_OFS_IGAIN, 32'h3FF);
      wr(SXP_OFS_NUM2, 32'h0);
      wr(SXP_OFS_NUM3, 32'h1234);
      wr(SXP_OFS_NUM4, 32'hFFFF_FFFF);
      rd(SXP_OFS_NUM2, 32'h1);
      for (int i = 0; i < 5; i++)
      begin
         t();
         di_in.num_assigned <= (i < 4);
         di_in.num_sel <= 2'(3 - i);
         s1();
         ck(gear_numerator_out, NX[i]);
      end
      // pulse trains against limits, inhibit off then on
      pl(1'b1, 8'd2, 1'b0, 32'd2);
      t();
      di_in.fwd_limit <= 1'b1;
      pl(1'b1, 8'd3, 1'b0, 32'd5);
      wr(SXP_OFS_SF1, 32'h0800);
      pl(1'b1, 8'd3, 1'b1, 32'd5);
      pl(1'b0, 8'd2, 1'b0, 32'd3);
      t();
      di_in.rev_limit <= 1'b1;
      pl(1'b0, 8'd2, 1'b0, 32'd3);
      // count clear on edge, then on level
      t();
      mode_in <= SXP_MODE_IPOS;
      di_in.clear <= 1'b1;
      di_in.fwd_limit <= 1'b0;
      di_in.rev_limit <= 1'b0;
      s1();
      ck(pulse_count_out, 32'h0);
      t();
      mode_in <= SXP_MODE_PPOS;
      pl(1'b1, 8'd3, 1'b0, 32'd3);
      wr(SXP_OFS_CLR_MODE, 32'h1);
      s1();
      ck(pulse_count_out, 32'h0);
      t();
      di_in.clear <= 1'b0;
      for (int i = 0; i < 3; i++)
      begin
         wr(SXP_OFS_SF1, {16'h0, SV[i]});
         s1();
         ck(det_en_out, {27'h0, DX[i]});
      end
      // selects by level, then by rising edge
      t();
      di_in.spd_sel <= 2'h2;
      di_in.trq_sel <= 2'h2;
      s1();
      ck({speed_select_out, torque_select_out}, 32'hA);
      wr(SXP_OFS_SF1, 32'h0003);
      t();
      di_in.spd_sel <= 2'h0;
      di_in.trq_sel <= 2'h0;
      s1();
      ck({speed_select_out, torque_select_out}, 32'hA);
      t();
      di_in.spd_sel <= 2'h1;
      di_in.trq_sel <= 2'h1;
      s1();
      ck({speed_select_out, torque_select_out}, 32'h5);
      // zero speed hold: lock, internal force, analog ramp
      t();
      mode_in <= SXP_MODE_SPD;
      di_in.zero_speed_hold <= 1'b1;
      s1();
      ck({clamp_active_out, clamp_lock_out, speed_cmd_out}, 32'h3_0005);
      wr(SXP_OFS_SF1, 32'h0400);
      s1();
      ck(speed_cmd_out, 32'h0);
      t();
      di_in.zero_speed_hold <= 1'b0;
      analog_source_in <= 1'b1;
      speed_cmd_in <= 16'h0050;
      clamp_threshold_in <= 16'h0100;
      s1();
      ck({clamp_active_out, speed_cmd_out}, 32'h0_0050);
      t();
      di_in.zero_speed_hold <= 1'b1;
      repeat (8) s1();
      ck({clamp_active_out, speed_cmd_out}, 32'h1_0000);
      t();
      di_in.zero_speed_hold <= 1'b0;
      s1();
      ck(speed_cmd_out, 32'h0050);
      // alarms and auto enable
      t();
      undervoltage_in <= 1'b1;
      t();
      undervoltage_in <= 1'b0;
      repeat (3) s1();
      ck({undervoltage_alarm_out, limit_alarm_out}, 32'h3);
      wr(SXP_OFS_SF2, 32'h0004);
      wr(SXP_OFS_AUTO, 32'h0010);
      s1();
      ck({undervoltage_alarm_out, limit_alarm_out}, 32'h0);
      t();
      di_in.servo_on <= 1'b1;
      s1();
      t();
      main_power_in <= 1'b1;
      repeat (2) s1();
      ck(motor_enable_out, 32'h0);
      wr(SXP_OFS_AUTO, 32'h0011);
      s1();
      ck(motor_enable_out, 32'h1);
      // inertia band upper edge
      t();
      semi_auto_in <= 1'b1;
      inertia_measured_in <= 16'd28;
      s1();
      ck(reestimate_out, 32'h1);
      t();
      inertia_measured_in <= 16'd27;
      s1();
      ck(reestimate_out, 32'h0);
      conclude();
   end
endmodule
